// ---- core/sli_pkg.sv ----
// constants, types and register map of the status lamp indicator
// What this block does
// - run lamp dark while slave state is INIT or BOOTSTRAP.
// - run lamp blinks continuously while slave state is PREOP.
// - run lamp single-flashes in SAFEOP; outputs held in safe state meanwhile.
// - run lamp lit steadily while slave state is OP.
// - low range: each current channel error lamp lit above the low overcurrent threshold.
// - high range: each current channel error lamp lit above the high overcurrent threshold.
// - each voltage channel error lamp lit when phase-to-neutral voltage exceeds threshold.
// - general error lamp is the OR of the other_errors inputs only; the channel error lamps do not feed it.
package sli_pkg;

	localparam int unsigned CLK_HZ           = 250_000_000;
	localparam int unsigned BLINK_PHASE_MS   = 200;
	localparam int unsigned BLINK_PHASE_CYC  = (CLK_HZ / 1000) * BLINK_PHASE_MS;
	localparam int unsigned FLASH_PHASES     = 6;
	localparam int unsigned NUM_CH           = 3;
	localparam int unsigned NUM_OTHER_ERR    = 8;

	// slave state machine codes as presented on the state input
	localparam logic [3:0] AL_INIT   = 4'h1;
	localparam logic [3:0] AL_PREOP  = 4'h2;
	localparam logic [3:0] AL_BOOT   = 4'h3;
	localparam logic [3:0] AL_SAFEOP = 4'h4;
	localparam logic [3:0] AL_OP     = 4'h8;

	typedef enum logic [3:0] {
		RUN_OFF   = 4'h1,
		RUN_BLINK = 4'h2,
		RUN_FLASH = 4'h4,
		RUN_ON    = 4'h8
	} sli_run_t;

	// byte addresses on the register bus
	localparam logic [4:0] ADDR_CTRL     = 5'h00;
	localparam logic [4:0] ADDR_STATUS   = 5'h04;
	localparam logic [4:0] ADDR_MASK     = 5'h08;
	localparam logic [4:0] ADDR_LAMPS    = 5'h0C;
	localparam logic [4:0] ADDR_OC_LOW   = 5'h10;
	localparam logic [4:0] ADDR_OC_HIGH  = 5'h14;
	localparam logic [4:0] ADDR_OV       = 5'h18;

	// control fields
	localparam int unsigned CTRL_RANGE_HIGH_BIT = 0;
	localparam logic [0:0]  CTRL_RESET          = 1'h0;

	// status and mask layout
	localparam int unsigned EV_OC_LSB    = 0;
	localparam int unsigned EV_OV_LSB    = 3;
	localparam int unsigned EV_GEN_BIT   = 6;
	localparam int unsigned EV_RUN_BIT   = 7;
	localparam int unsigned EV_W         = 8;
	localparam logic [7:0]  MASK_RESET   = 8'h00;

	// lamp readback layout
	localparam int unsigned LAMP_RUN_BIT  = 12;
	localparam int unsigned LAMP_GEN_BIT  = 13;
	localparam int unsigned LAMP_SAFE_BIT = 14;
	localparam int unsigned LAMP_OCG_LSB  = 0;
	localparam int unsigned LAMP_OC_LSB   = 3;
	localparam int unsigned LAMP_OVG_LSB  = 6;
	localparam int unsigned LAMP_OV_LSB   = 9;

	// threshold reset values, magnitude in converter codes
	localparam logic [15:0] OC_LOW_RESET  = 16'h7D1C;
	localparam logic [15:0] OC_HIGH_RESET = 16'h7FE4;
	localparam logic [15:0] OV_RESET      = 16'h7FFF;

endpackage

// ---- core/sli_blink.sv ----
// blink and single-flash pattern generator for the run lamp
`timescale 1ns/10ps
module sli_blink #(
	parameter int unsigned PHASE_CYC = sli_pkg::BLINK_PHASE_CYC
) (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic ce,
	output logic      blink_on,
	output logic      flash_on
);
	import sli_pkg::*;

	logic [31:0] tick_cnt_ff;
	logic [2:0]  phase_ff;
	logic        blink_ff;
	logic        flash_ff;
	logic        tick;

	assign tick     = (tick_cnt_ff == 32'(PHASE_CYC - 1));
	assign blink_on = blink_ff;
	assign flash_on = flash_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_ff <= 32'h0;
		end else if (ce) begin
			tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
		end
	end

	// blink: equal on and off phases
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			blink_ff <= 1'b0;
		end else if (ce && tick) begin
			blink_ff <= ~blink_ff;
		end
	end

	// single flash: one lit phase, then the rest dark, so it reads apart from blinking
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_ff <= 3'h0;
			flash_ff <= 1'b0;
		end else if (ce && tick) begin
			phase_ff <= (phase_ff == 3'(FLASH_PHASES - 1)) ? 3'h0 : phase_ff + 3'h1;
			flash_ff <= (phase_ff == 3'(FLASH_PHASES - 1));
		end
	end

endmodule

// ---- core/sli_top.sv ----
// status lamp indicator: run lamp, channel lamps, error lamp and register slave
`timescale 1ns/10ps
module sli_top #(
	parameter int unsigned BLINK_PHASE_CYC_P = sli_pkg::BLINK_PHASE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic [3:0]  slave_state,
	input  wire logic [15:0] phase_a_current,
	input  wire logic [15:0] phase_b_current,
	input  wire logic [15:0] phase_c_current,
	input  wire logic [15:0] phase_a_voltage,
	input  wire logic [15:0] phase_b_voltage,
	input  wire logic [15:0] phase_c_voltage,
	input  wire logic [sli_pkg::NUM_OTHER_ERR-1:0] other_errors,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	output logic             run_lamp,
	output logic             general_error_lamp,
	output logic             outputs_safe_hold,
	output logic             phase_a_current_good_lamp,
	output logic             phase_b_current_good_lamp,
	output logic             phase_c_current_good_lamp,
	output logic             phase_a_overcurrent_lamp,
	output logic             phase_b_overcurrent_lamp,
	output logic             phase_c_overcurrent_lamp,
	output logic             phase_a_voltage_good_lamp,
	output logic             phase_b_voltage_good_lamp,
	output logic             phase_c_voltage_good_lamp,
	output logic             phase_a_overvoltage_lamp,
	output logic             phase_b_overvoltage_lamp,
	output logic             phase_c_overvoltage_lamp
);
	import sli_pkg::*;

	logic [15:0]        cur_in   [NUM_CH];
	logic [15:0]        volt_in  [NUM_CH];
	logic [NUM_CH-1:0]  oc_ff;
	logic [NUM_CH-1:0]  ocg_ff;
	logic [NUM_CH-1:0]  ov_ff;
	logic [NUM_CH-1:0]  ovg_ff;
	logic [NUM_CH-1:0]  nxt_oc;
	logic [NUM_CH-1:0]  nxt_ov;
	sli_run_t           run_mode_ff;
	sli_run_t           nxt_run_mode;
	logic               run_lamp_ff;
	logic               nxt_run_lamp;
	logic               gen_err_ff;
	logic               safe_hold_ff;
	logic               blink_on;
	logic               flash_on;
	logic               range_high_ff;
	logic [15:0]        oc_low_thr_ff;
	logic [15:0]        oc_high_thr_ff;
	logic [15:0]        ov_thr_ff;
	logic [15:0]        oc_thr;
	logic [EV_W-1:0]    status_ff;
	logic [EV_W-1:0]    mask_ff;
	logic [EV_W-1:0]    events;
	logic [EV_W-1:0]    status_kept;
	logic               irq_ff;
	logic               wait_ff;
	logic [31:0]        rdata_ff;
	logic               req;
	logic               wr_go;
	logic               rd_clr;
	logic [15:0]        lamps;
	logic [31:0]        nxt_rdata;

	// magnitude of a signed sample; 17 bits so that the most negative code is not lost
	function automatic logic [16:0] mag(input logic [15:0] v);
		mag = v[15] ? (17'h0 - {v[15], v}) : {1'b0, v};
	endfunction

	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		wr16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	assign cur_in[0]  = phase_a_current;
	assign cur_in[1]  = phase_b_current;
	assign cur_in[2]  = phase_c_current;
	assign volt_in[0] = phase_a_voltage;
	assign volt_in[1] = phase_b_voltage;
	assign volt_in[2] = phase_c_voltage;

	sli_blink #(
		.PHASE_CYC (BLINK_PHASE_CYC_P)
	) u_blink (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.ce       (ce),
		.blink_on (blink_on),
		.flash_on (flash_on)
	);

	assign oc_thr = range_high_ff ? oc_high_thr_ff : oc_low_thr_ff;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			assign nxt_oc[ch] = mag(cur_in[ch]) > {1'b0, oc_thr};
			assign nxt_ov[ch] = mag(volt_in[ch]) > {1'b0, ov_thr_ff};

			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					oc_ff[ch]  <= 1'b0;
					ov_ff[ch]  <= 1'b0;
					ocg_ff[ch] <= 1'b0;
					ovg_ff[ch] <= 1'b0;
				end else if (ce) begin
					oc_ff[ch]  <= nxt_oc[ch];
					ov_ff[ch]  <= nxt_ov[ch];
					// good lamp from same next value
					ocg_ff[ch] <= ~nxt_oc[ch];
					ovg_ff[ch] <= ~nxt_ov[ch];
				end
			end

			property p_oc_lamp;
				@(posedge clk_sys) disable iff (!resetn)
				ce |=> oc_ff[ch] == ($past(mag(cur_in[ch])) > {1'b0, $past(oc_thr)});
			endproperty
			a_oc_lamp: assert property (p_oc_lamp) else $error("overcurrent lamp wrong");

			property p_ov_lamp;
				@(posedge clk_sys) disable iff (!resetn)
				ce && mag(volt_in[ch]) > {1'b0, ov_thr_ff} |=> ov_ff[ch] && !ovg_ff[ch];
			endproperty
			a_ov_lamp: assert property (p_ov_lamp) else $error("overvoltage lamp not lit");

			property p_excl;
				@(posedge clk_sys) disable iff (!resetn)
				!(ocg_ff[ch] && oc_ff[ch]) && !(ovg_ff[ch] && ov_ff[ch]);
			endproperty
			a_excl: assert property (p_excl) else $error("good and error lamp lit together");
		end
	endgenerate

	always_comb begin
		case (slave_state)
			AL_PREOP:  nxt_run_mode = RUN_BLINK;
			AL_SAFEOP: nxt_run_mode = RUN_FLASH;
			AL_OP:     nxt_run_mode = RUN_ON;
			default:   nxt_run_mode = RUN_OFF;
		endcase
	end

	always_comb begin
		case (run_mode_ff)
			RUN_BLINK: nxt_run_lamp = blink_on;
			RUN_FLASH: nxt_run_lamp = flash_on;
			RUN_ON:    nxt_run_lamp = 1'b1;
			default:   nxt_run_lamp = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			run_mode_ff <= RUN_OFF;
			run_lamp_ff <= 1'b0;
		end else if (ce) begin
			run_mode_ff <= nxt_run_mode;
			run_lamp_ff <= nxt_run_lamp;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			safe_hold_ff <= 1'b0;
		end else if (ce) begin
			safe_hold_ff <= (slave_state == AL_SAFEOP);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			gen_err_ff <= 1'b0;
		end else if (ce) begin
			gen_err_ff <= |other_errors;
		end
	end

	// events: rising edge of each error lamp, and a run mode change
	always_comb begin
		events                        = '0;
		events[EV_OC_LSB +: NUM_CH]   = nxt_oc & ~oc_ff;
		events[EV_OV_LSB +: NUM_CH]   = nxt_ov & ~ov_ff;
		events[EV_GEN_BIT]            = (|other_errors) & ~gen_err_ff;
		events[EV_RUN_BIT]            = (nxt_run_mode != run_mode_ff);
	end

	// bus slave: one wait cycle, answer at the second edge
	assign req    = avs_read || avs_write;
	assign wr_go  = avs_write && !wait_ff;
	assign rd_clr = avs_read && !wait_ff && (avs_address == ADDR_STATUS);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wait_ff <= 1'b1;
		end else if (ce) begin
			wait_ff <= !(req && wait_ff);
		end
	end

	assign lamps = {1'b0, safe_hold_ff, gen_err_ff, run_lamp_ff, ov_ff, ovg_ff, oc_ff, ocg_ff};

	always_comb begin
		case (avs_address)
			ADDR_CTRL:    nxt_rdata = {31'h0, range_high_ff};
			ADDR_STATUS:  nxt_rdata = {24'h0, status_ff};
			ADDR_MASK:    nxt_rdata = {24'h0, mask_ff};
			ADDR_LAMPS:   nxt_rdata = {16'h0, lamps};
			ADDR_OC_LOW:  nxt_rdata = {16'h0, oc_low_thr_ff};
			ADDR_OC_HIGH: nxt_rdata = {16'h0, oc_high_thr_ff};
			ADDR_OV:      nxt_rdata = {16'h0, ov_thr_ff};
			default:      nxt_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 32'h0;
		end else if (ce && avs_read && wait_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			range_high_ff  <= CTRL_RESET;
			mask_ff        <= MASK_RESET;
			oc_low_thr_ff  <= OC_LOW_RESET;
			oc_high_thr_ff <= OC_HIGH_RESET;
			ov_thr_ff      <= OV_RESET;
		end else if (ce && wr_go) begin
			case (avs_address)
				ADDR_CTRL: begin
					if (avs_byteenable[0]) begin
						range_high_ff <= avs_writedata[CTRL_RANGE_HIGH_BIT];
					end
				end
				ADDR_MASK: begin
					if (avs_byteenable[0]) begin
						mask_ff <= avs_writedata[EV_W-1:0];
					end
				end
				ADDR_OC_LOW:  oc_low_thr_ff  <= wr16(oc_low_thr_ff, avs_writedata, avs_byteenable);
				ADDR_OC_HIGH: oc_high_thr_ff <= wr16(oc_high_thr_ff, avs_writedata, avs_byteenable);
				ADDR_OV:      ov_thr_ff      <= wr16(ov_thr_ff, avs_writedata, avs_byteenable);
				default: begin
				end
			endcase
		end
	end

	// a read clears only the bits it returned, so an event during the wait cycle survives
	assign status_kept = rd_clr ? (status_ff & ~rdata_ff[EV_W-1:0]) : status_ff;

	// sticky status: a new event wins over the read that clears
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status_ff <= '0;
		end else if (ce) begin
			status_ff <= status_kept | events;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= |((status_kept | events) & mask_ff);
		end
	end

	assign avs_readdata              = rdata_ff;
	assign avs_waitrequest           = wait_ff;
	assign irq                       = irq_ff;
	assign run_lamp                  = run_lamp_ff;
	assign general_error_lamp        = gen_err_ff;
	assign outputs_safe_hold         = safe_hold_ff;
	assign phase_a_current_good_lamp = ocg_ff[0];
	assign phase_b_current_good_lamp = ocg_ff[1];
	assign phase_c_current_good_lamp = ocg_ff[2];
	assign phase_a_overcurrent_lamp  = oc_ff[0];
	assign phase_b_overcurrent_lamp  = oc_ff[1];
	assign phase_c_overcurrent_lamp  = oc_ff[2];
	assign phase_a_voltage_good_lamp = ovg_ff[0];
	assign phase_b_voltage_good_lamp = ovg_ff[1];
	assign phase_c_voltage_good_lamp = ovg_ff[2];
	assign phase_a_overvoltage_lamp  = ov_ff[0];
	assign phase_b_overvoltage_lamp  = ov_ff[1];
	assign phase_c_overvoltage_lamp  = ov_ff[2];

	property p_run_dark;
		@(posedge clk_sys) disable iff (!resetn)
		ce && (slave_state == AL_INIT || slave_state == AL_BOOT) ##1 ce |=> !run_lamp_ff;
	endproperty
	a_run_dark: assert property (p_run_dark) else $error("run lamp lit in init or boot");

	property p_run_blink;
		@(posedge clk_sys) disable iff (!resetn)
		ce && run_mode_ff == RUN_BLINK |=> run_lamp_ff == $past(blink_on);
	endproperty
	a_run_blink: assert property (p_run_blink) else $error("run lamp not following blink");

	property p_run_flash;
		@(posedge clk_sys) disable iff (!resetn)
		ce && slave_state == AL_SAFEOP |=> safe_hold_ff && run_mode_ff == RUN_FLASH;
	endproperty
	a_run_flash: assert property (p_run_flash) else $error("safeop not flashing or not safe");

	property p_run_on;
		@(posedge clk_sys) disable iff (!resetn)
		ce && slave_state == AL_OP ##1 ce |=> run_lamp_ff;
	endproperty
	a_run_on: assert property (p_run_on) else $error("run lamp dark in op");

	property p_gen_err;
		@(posedge clk_sys) disable iff (!resetn)
		ce |=> gen_err_ff == (|$past(other_errors));
	endproperty
	a_gen_err: assert property (p_gen_err) else $error("general error lamp not the or");

endmodule

// ---- tb/sli_lamp_panel.sv ----
// operator panel model: counts lit run lamp cycles and good/error clashes
`timescale 1ns/10ps
module sli_lamp_panel (
	input  wire logic       clk_sys,
	input  wire logic       watch,
	input  wire logic       run_lamp,
	input  wire logic [2:0] cur_good,
	input  wire logic [2:0] cur_err,
	input  wire logic [2:0] vol_good,
	input  wire logic [2:0] vol_err,
	output int              lit_cycles,
	output int              clash_cycles
);
	initial begin
		lit_cycles = 0;
		clash_cycles = 0;
	end
	always @(posedge clk_sys) begin
		if (!watch)
			lit_cycles <= 0;
		else if (run_lamp === 1'b1)
			lit_cycles <= lit_cycles + 1;
	end
	always @(posedge clk_sys) begin
		if (((cur_good & cur_err) | (vol_good & vol_err)) !== 3'b000)
			clash_cycles <= clash_cycles + 1;
	end
endmodule

// ---- tb/status_led_indicator_test.sv ----
// self-checking bench of the status lamp indicator
`timescale 1ns/10ps
module status_led_indicator_test;
	import sli_pkg::*;
	localparam int PH  = 4;
	localparam int WIN = 12 * PH;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b1;
	logic [3:0]  slave_state = AL_INIT;
	logic [15:0] cur_a = 16'h0, cur_b = 16'h0, cur_c = 16'h0;
	logic [15:0] vol_a = 16'h0, vol_b = 16'h0, vol_c = 16'h0;
	logic [7:0]  other_errors = 8'h00;
	logic [4:0]  avs_address = 5'h00;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        avs_read = 1'b0, avs_write = 1'b0, watch = 1'b0, ce = 1'b1;
	logic [31:0] avs_writedata = 32'h0, rdata;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, irq, run_lamp, general_error_lamp, outputs_safe_hold;
	wire  [2:0]  cgood, oclamp, vgood, ovlamp;
	int          lit_cycles, clash_cycles;
	int          err_total = 0;
	int          samples_checked = 0;
	logic [3:0]  st_tab [6] = '{AL_INIT, AL_BOOT, AL_PREOP, AL_SAFEOP, AL_OP, 4'h0};
	int          lit_tab [6] = '{0, 0, WIN / 2, WIN / FLASH_PHASES, WIN, 0};

	always #2 clk_sys = ~clk_sys;

	sli_top #(.BLINK_PHASE_CYC_P(PH)) i_dut (
		.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .slave_state(slave_state),
		.phase_a_current(cur_a), .phase_b_current(cur_b), .phase_c_current(cur_c),
		.phase_a_voltage(vol_a), .phase_b_voltage(vol_b), .phase_c_voltage(vol_c),
		.other_errors(other_errors), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.run_lamp(run_lamp), .general_error_lamp(general_error_lamp),
		.outputs_safe_hold(outputs_safe_hold),
		.phase_a_current_good_lamp(cgood[0]), .phase_b_current_good_lamp(cgood[1]),
		.phase_c_current_good_lamp(cgood[2]), .phase_a_overcurrent_lamp(oclamp[0]),
		.phase_b_overcurrent_lamp(oclamp[1]), .phase_c_overcurrent_lamp(oclamp[2]),
		.phase_a_voltage_good_lamp(vgood[0]), .phase_b_voltage_good_lamp(vgood[1]),
		.phase_c_voltage_good_lamp(vgood[2]), .phase_a_overvoltage_lamp(ovlamp[0]),
		.phase_b_overvoltage_lamp(ovlamp[1]), .phase_c_overvoltage_lamp(ovlamp[2])
	);

	sli_lamp_panel i_panel (
		.clk_sys(clk_sys), .watch(watch), .run_lamp(run_lamp), .cur_good(cgood),
		.cur_err(oclamp), .vol_good(vgood), .vol_err(ovlamp),
		.lit_cycles(lit_cycles), .clash_cycles(clash_cycles)
	);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until waitrequest is seen low, then released
	task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] wdata);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= addr;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= wdata;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			$display("ERROR bus wait expected 0 seen %b", avs_waitrequest);
			tally_and_finish();
		end
	endtask

	task automatic rd_chk(input string what, input logic [4:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h0);
		chk(what, exp, rdata);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	initial begin
		resetn <= 1'b0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		settle(2);
		rd_chk("oc low reset", ADDR_OC_LOW, {16'h0, OC_LOW_RESET});
		rd_chk("oc high reset", ADDR_OC_HIGH, {16'h0, OC_HIGH_RESET});
		rd_chk("ov reset", ADDR_OV, {16'h0, OV_RESET});
		rd_chk("mask reset", ADDR_MASK, {24'h0, MASK_RESET});
		rd_chk("ctrl reset", ADDR_CTRL, 32'h0);
		rd_chk("unmapped", 5'h1C, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			slave_state <= st_tab[i];
			settle(4);
			chk("safe hold", {31'h0, st_tab[i] == AL_SAFEOP}, {31'h0, outputs_safe_hold});
			@(posedge clk_sys);
			watch <= 1'b1;
			repeat (WIN) @(posedge clk_sys);
			watch <= 1'b0;
			#1;
			chk("run lit cycles", lit_tab[i], lit_cycles);
		end
		@(posedge clk_sys);
		slave_state <= AL_OP;
		settle(4);
		rd_chk("status run change", ADDR_STATUS, 32'h80);
		$display("test run lamp done");
		bus(1'b1, ADDR_OC_LOW, 32'h0100);
		bus(1'b1, ADDR_OC_HIGH, 32'h0200);
		@(posedge clk_sys);
		cur_a <= 16'h0101;
		cur_b <= 16'h0100;
		cur_c <= 16'hFEFF;
		settle(3);
		chk("overcurrent low", 32'h5, {29'h0, oclamp});
		chk("current good low", 32'h2, {29'h0, cgood});
		rd_chk("lamps", ADDR_LAMPS, 32'h11EA);
		bus(1'b1, ADDR_CTRL, 32'h1);
		settle(3);
		chk("overcurrent high", 32'h0, {29'h0, oclamp});
		@(posedge clk_sys);
		cur_b <= 16'h0201;
		settle(3);
		chk("overcurrent high b", 32'h2, {29'h0, oclamp});
		bus(1'b1, ADDR_CTRL, 32'h0);
		settle(3);
		chk("overcurrent low all", 32'h7, {29'h0, oclamp});
		chk("current good none", 32'h0, {29'h0, cgood});
		bus(1'b1, ADDR_OV, 32'h0300);
		@(posedge clk_sys);
		vol_a <= 16'h0300;
		vol_b <= 16'hFCFF;
		vol_c <= 16'h7FFF;
		settle(3);
		chk("overvoltage", 32'h6, {29'h0, ovlamp});
		chk("voltage good", 32'h1, {29'h0, vgood});
		@(posedge clk_sys);
		avs_byteenable <= 4'h1;
		bus(1'b1, ADDR_OV, 32'hAB55);
		avs_byteenable <= 4'hF;
		rd_chk("ov byte lane", ADDR_OV, 32'h0355);
		settle(3);
		chk("overvoltage lane thr", 32'h4, {29'h0, ovlamp});
		chk("voltage good lane thr", 32'h3, {29'h0, vgood});
		$display("test channel lamps done");
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_sys);
			other_errors <= (i < 8) ? (8'h01 << i) : 8'h00;
			settle(3);
			chk("general error", {31'h0, i < 8}, {31'h0, general_error_lamp});
		end
		$display("test general error done");
		@(posedge clk_sys);
		cur_a <= 16'h0;
		cur_b <= 16'h0;
		cur_c <= 16'h0;
		settle(4);
		bus(1'b0, ADDR_STATUS, 32'h0);
		bus(1'b1, ADDR_MASK, 32'h0);
		@(posedge clk_sys);
		cur_b <= 16'h7000;
		settle(4);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd_chk("status masked", ADDR_STATUS, 32'h02);
		bus(1'b1, ADDR_MASK, 32'h01);
		rd_chk("mask", ADDR_MASK, 32'h01);
		@(posedge clk_sys);
		cur_a <= 16'h7000;
		settle(4);
		chk("irq raised", 32'h1, {31'h0, irq});
		rd_chk("status", ADDR_STATUS, 32'h01);
		settle(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		@(posedge clk_sys);
		ce <= 1'b0;
		cur_c <= 16'h7000;
		settle(3);
		chk("frozen overcurrent", 32'h3, {29'h0, oclamp});
		@(posedge clk_sys);
		ce <= 1'b1;
		settle(3);
		chk("enabled overcurrent", 32'h7, {29'h0, oclamp});
		chk("lamp clash cycles", 32'h0, clash_cycles);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule
